// File: hdl/key_fs_divider.sv
// divider making the low-speed clock enable pulse from pclk
`timescale 1ns/1ps
`default_nettype none
module key_slow_divider
(
   input wire logic pclk,
   input wire logic presetn,
   output logic slow_tick
);

   logic [10:0] div_count;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_count <= 11'h000;
         slow_tick <= 1'b0;
      end
      else if (div_count == key_wakeup_pkg::SLOW_DIV_COUNT)
      begin
         div_count <= 11'h000;
         slow_tick <= 1'b1;
      end
      else
      begin
         div_count <= div_count + 11'h001;
         slow_tick <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// File: hdl/key_wakeup_detector.sv
// key wake-up detector: fourteen key inputs, one shared request, apb registers
//
// Overview of operation
// - fourteen key inputs for wake-up or interrupt
// - each key has its own use-enable
// - all keys share one interrupt request
// - per-key condition: rise, fall, high, low
// - active-high result to clock gen, interrupt ctl
// - select 1: all keys end standby together
// - select 0 (reset): keys are plain interrupts
// - writing 1010 to clear drops all requests
// - earlier detections vanish with the clearing write
// - detection after the clear raises request again
// - bit 0 switches all pull-ups together
// - unused keys are never pulled up
// - bit 1 selects static or pulsed pull-ups
// - pulse width 4, 8, 16, 32 slow periods
// - interval 128, 256, 512, 1024 slow periods
// - dynamic: edge sampled at the slow tick that ends the pulse
// - static or off: conditions watched continuously
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module key_wakeup_detector
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [13:0] key_pin,
   output logic [13:0] key_pullup_on,
   output logic cg_key_detect,
   output logic interrupt_controller_unit_key_request
);

   // ****************************************
   // declarations
   // ****************************************
   localparam int N = key_wakeup_pkg::NUM_KEYS;
   localparam int PW = key_wakeup_pkg::PHASE_W;

   key_wakeup_pkg::apb_state_t apb_state;
   logic [5:0] reg_index;
   logic setup_hit;
   logic addr_hit;
   logic access_done;
   logic write_fire;
   logic clear_fire;
   logic [31:0] read_value;

   logic [1:0] key_cond [N];
   logic [N-1:0] key_enable;
   logic pullup_enable;
   logic dynamic_pullup_select;
   logic [1:0] pullup_pulse_select;
   logic [1:0] pullup_interval_select;
   logic wakeup_source_select;

   logic [N-1:0] key_meta;
   logic [N-1:0] key_sync;
   logic [N-1:0] key_prev;
   logic [N-1:0] dyn_sample;
   logic [N-1:0] hit;
   logic any_hit;
   logic next_key_request;

   logic slow_tick;
   logic dyn_on;
   logic [PW-1:0] phase_count;
   logic [PW-1:0] pulse_len;
   logic [PW-1:0] interval_len;
   logic t1_active;
   logic sample_strobe;

   // ****************************************
   // apb slave
   // ****************************************
   assign reg_index = paddr[7:2];
   assign setup_hit = (paddr[1:0] == 2'h0) && (reg_index < key_wakeup_pkg::NUM_KEYS_IDX);
   assign addr_hit = setup_hit
      || paddr == key_wakeup_pkg::PULLUP_CTRL_OFS
      || paddr == key_wakeup_pkg::CLEAR_OFS
      || paddr == key_wakeup_pkg::WAKE_SEL_OFS
      || paddr == key_wakeup_pkg::STATUS_OFS
      || paddr == key_wakeup_pkg::LEVEL_OFS;
   assign access_done = (apb_state == key_wakeup_pkg::APB_ANSWER) && psel && penable;
   assign write_fire = access_done && pwrite && addr_hit;
   assign clear_fire = write_fire && paddr == key_wakeup_pkg::CLEAR_OFS
      && pwdata[3:0] == key_wakeup_pkg::CLEAR_CODE;

   always_comb
   begin
      read_value = 32'h0000_0000;
      if (setup_hit)
      begin
         read_value[key_wakeup_pkg::SETUP_EN_BIT] = key_enable[reg_index[3:0]];
         read_value[key_wakeup_pkg::SETUP_COND_LSB +: 2] = key_cond[reg_index[3:0]];
      end
      else
      begin
         case (paddr)
            key_wakeup_pkg::PULLUP_CTRL_OFS:
            begin
               read_value[key_wakeup_pkg::PU_EN_BIT] = pullup_enable;
               read_value[key_wakeup_pkg::PU_DYN_BIT] = dynamic_pullup_select;
               read_value[key_wakeup_pkg::PU_PULSE_LSB +: 2] = pullup_pulse_select;
               read_value[key_wakeup_pkg::PU_INTERVAL_LSB +: 2] = pullup_interval_select;
            end
            key_wakeup_pkg::WAKE_SEL_OFS: read_value[0] = wakeup_source_select;
            key_wakeup_pkg::STATUS_OFS:
            begin
               read_value[key_wakeup_pkg::STATUS_REQ_BIT] = interrupt_controller_unit_key_request;
               read_value[key_wakeup_pkg::STATUS_CG_BIT] = cg_key_detect;
            end
            key_wakeup_pkg::LEVEL_OFS: read_value[N-1:0] = key_sync;
            default: read_value = 32'h0000_0000;
         endcase
      end
   end

   // answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         apb_state <= key_wakeup_pkg::APB_SETUP;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         case (apb_state)
            key_wakeup_pkg::APB_SETUP:
            begin
               if (psel && penable)
               begin
                  apb_state <= key_wakeup_pkg::APB_ANSWER;
                  pready <= 1'b1;
                  pslverr <= !addr_hit;
                  prdata <= pwrite ? 32'h0000_0000 : read_value;
               end
            end
            key_wakeup_pkg::APB_ANSWER:
            begin
               apb_state <= key_wakeup_pkg::APB_SETUP;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
            default:
            begin
               apb_state <= key_wakeup_pkg::APB_SETUP;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pullup_enable <= key_wakeup_pkg::PULLUP_CTRL_RESET[key_wakeup_pkg::PU_EN_BIT];
         dynamic_pullup_select <= key_wakeup_pkg::PULLUP_CTRL_RESET[key_wakeup_pkg::PU_DYN_BIT];
         pullup_pulse_select <= key_wakeup_pkg::PULLUP_CTRL_RESET[key_wakeup_pkg::PU_PULSE_LSB +: 2];
         pullup_interval_select <= key_wakeup_pkg::PULLUP_CTRL_RESET[key_wakeup_pkg::PU_INTERVAL_LSB +: 2];
      end
      else if (write_fire && paddr == key_wakeup_pkg::PULLUP_CTRL_OFS)
      begin
         pullup_enable <= pwdata[key_wakeup_pkg::PU_EN_BIT];
         dynamic_pullup_select <= pwdata[key_wakeup_pkg::PU_DYN_BIT];
         pullup_pulse_select <= pwdata[key_wakeup_pkg::PU_PULSE_LSB +: 2];
         pullup_interval_select <= pwdata[key_wakeup_pkg::PU_INTERVAL_LSB +: 2];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wakeup_source_select <= key_wakeup_pkg::WAKE_SEL_RESET;
      else if (write_fire && paddr == key_wakeup_pkg::WAKE_SEL_OFS)
         wakeup_source_select <= pwdata[0];
   end

   // ****************************************
   // key inputs: sync, setup, detection
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         key_meta <= '1;
         key_sync <= '1;
         key_prev <= '1;
      end
      else
      begin
         key_meta <= key_pin;
         key_sync <= key_meta;
         key_prev <= key_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dyn_sample <= '1;
      else if (sample_strobe)
         dyn_sample <= key_sync;
   end

   genvar gi;
   generate
      for (gi = 0; gi < N; gi = gi + 1)
      begin : g_key
         logic cont_hit;
         logic dyn_hit;

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               key_enable[gi] <= 1'b0;
               key_cond[gi] <= key_wakeup_pkg::COND_RESET;
            end
            else if (write_fire && setup_hit && reg_index == 6'(gi))
            begin
               key_enable[gi] <= pwdata[key_wakeup_pkg::SETUP_EN_BIT];
               key_cond[gi] <= pwdata[key_wakeup_pkg::SETUP_COND_LSB +: 2];
            end
         end

         always_comb
         begin
            case (key_cond[gi])
               key_wakeup_pkg::COND_LOW: cont_hit = !key_sync[gi];
               key_wakeup_pkg::COND_HIGH: cont_hit = key_sync[gi];
               key_wakeup_pkg::COND_FALL: cont_hit = key_prev[gi] && !key_sync[gi];
               key_wakeup_pkg::COND_RISE: cont_hit = !key_prev[gi] && key_sync[gi];
               default: cont_hit = 1'b0;
            endcase
            // level codes are not supported while pulsing
            case (key_cond[gi])
               key_wakeup_pkg::COND_FALL: dyn_hit = dyn_sample[gi] && !key_sync[gi];
               key_wakeup_pkg::COND_RISE: dyn_hit = !dyn_sample[gi] && key_sync[gi];
               default: dyn_hit = 1'b0;
            endcase
         end

         assign hit[gi] = key_enable[gi] && (dyn_on ? (sample_strobe && dyn_hit) : cont_hit);
      end
   endgenerate

   // ****************************************
   // shared request
   // ****************************************
   assign any_hit = |hit;
   // a hit in the clearing cycle survives
   assign next_key_request = any_hit || (interrupt_controller_unit_key_request && !clear_fire);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         interrupt_controller_unit_key_request <= 1'b0;
         cg_key_detect <= 1'b0;
      end
      else
      begin
         interrupt_controller_unit_key_request <= next_key_request;
         cg_key_detect <= next_key_request && wakeup_source_select;
      end
   end

   // ****************************************
   // pull-up control
   // ****************************************
   key_slow_divider u_slow_divider
   (
      .pclk(pclk),
      .presetn(presetn),
      .slow_tick(slow_tick)
   );

   assign dyn_on = pullup_enable && dynamic_pullup_select;
   assign pulse_len = key_wakeup_pkg::PULSE_BASE_TICKS << pullup_pulse_select;
   assign interval_len = key_wakeup_pkg::INTERVAL_BASE_TICKS << pullup_interval_select;
   assign t1_active = dyn_on && (phase_count < pulse_len);
   assign sample_strobe = dyn_on && slow_tick && (phase_count == pulse_len - 11'h001);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase_count <= 11'h000;
      else if (!dyn_on)
         phase_count <= 11'h000;
      else if (slow_tick)
         phase_count <= (phase_count >= interval_len - 11'h001) ? 11'h000 : phase_count + 11'h001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         key_pullup_on <= '0;
      else if (!pullup_enable)
         key_pullup_on <= '0;
      else if (dynamic_pullup_select)
         key_pullup_on <= key_enable & {N{t1_active}};
      else
         key_pullup_on <= key_enable;
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("apb access not answered after one cycle");
   clear_drops_a: assert property (clear_fire && !any_hit |=> !interrupt_controller_unit_key_request)
      else $error("coded clear left the request set");
   hit_sets_a: assert property (any_hit |=> interrupt_controller_unit_key_request ##0 (cg_key_detect == $past(wakeup_source_select)))
      else $error("detection did not raise the request");
   request_holds_a: assert property (interrupt_controller_unit_key_request && !clear_fire |=> interrupt_controller_unit_key_request)
      else $error("request dropped without clearing write");
   cg_gated_a: assert property (!wakeup_source_select |=> !cg_key_detect)
      else $error("wake-up signal with select at zero");
   unused_nopull_a: assert property (##1 (key_pullup_on & ~$past(key_enable)) == '0)
      else $error("unused key pulled up");
   static_pull_a: assert property (pullup_enable && !dynamic_pullup_select |=> key_pullup_on == $past(key_enable))
      else $error("static pull-up does not follow enables");
   pull_off_a: assert property (!pullup_enable |=> key_pullup_on == '0)
      else $error("pull-up on while disabled");
   pulse_end_a: assert property (dyn_on && slow_tick && phase_count == pulse_len - 11'h001 && $stable(pulse_len)
      |=> !t1_active || !dyn_on || $changed(pulse_len))
      else $error("pull-up pulse too long");
   interval_wrap_a: assert property (dyn_on && slow_tick && phase_count == interval_len - 11'h001
      |=> phase_count == 11'h000)
      else $error("pull-up interval did not restart");
   sample_window_a: assert property (sample_strobe |-> t1_active ##1 (dyn_sample == $past(key_sync)))
      else $error("dynamic sample outside pull-up pulse");
   dyn_level_a: assert property (dyn_on && !sample_strobe |-> hit == '0)
      else $error("dynamic mode detected between samples");

endmodule
`default_nettype wire

// File: hdl/key_wakeup_pkg.sv
// constants, field layout and types for the key wake-up detector
package key_wakeup_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_KEYS = 14;
   localparam int ADDR_W = 8;
   localparam int PHASE_W = 11;
   localparam logic [5:0] NUM_KEYS_IDX = 6'h0E;

   // ****************************************
   // register byte offsets
   // ****************************************
   // key_input_setup_regs for key i sit at SETUP_BASE_OFS + 4*i
   localparam logic [7:0] SETUP_BASE_OFS = 8'h00;
   localparam logic [7:0] PULLUP_CTRL_OFS = 8'h38;
   localparam logic [7:0] CLEAR_OFS = 8'h3C;
   localparam logic [7:0] WAKE_SEL_OFS = 8'h40;
   localparam logic [7:0] STATUS_OFS = 8'h44;
   localparam logic [7:0] LEVEL_OFS = 8'h48;

   // ****************************************
   // field positions
   // ****************************************
   localparam int SETUP_EN_BIT = 0;
   localparam int SETUP_COND_LSB = 4;
   localparam int PU_EN_BIT = 0;
   localparam int PU_DYN_BIT = 1;
   localparam int PU_PULSE_LSB = 2;
   localparam int PU_INTERVAL_LSB = 4;
   localparam int STATUS_REQ_BIT = 0;
   localparam int STATUS_CG_BIT = 1;

   // ****************************************
   // codes and reset values
   // ****************************************
   localparam logic [3:0] CLEAR_CODE = 4'hA;
   localparam logic [1:0] COND_RESET = 2'h2;
   localparam logic [5:0] PULLUP_CTRL_RESET = 6'h00;
   localparam logic WAKE_SEL_RESET = 1'b0;

   // ****************************************
   // timing
   // ****************************************
   localparam int PCLK_HZ = 50_000_000;
   localparam int SLOW_HZ = 32_768;
   localparam logic [10:0] SLOW_DIV_COUNT = 11'(PCLK_HZ / SLOW_HZ - 1);
   // pulse width and interval in low_speed_clock periods, code 00
   localparam logic [PHASE_W-1:0] PULSE_BASE_TICKS = 11'h004;
   localparam logic [PHASE_W-1:0] INTERVAL_BASE_TICKS = 11'h080;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      COND_LOW = 2'h0,
      COND_HIGH = 2'h1,
      COND_FALL = 2'h2,
      COND_RISE = 2'h3
   } cond_t;

   typedef enum logic [1:0] {
      APB_SETUP = 2'h1,
      APB_ANSWER = 2'h2
   } apb_state_t;

endpackage

// File: verif/key_switch_model.sv
// key switch and pin model for the key wake-up detector
`timescale 1ns/1ps
`default_nettype none
module key_switch_model
(
   input wire logic pclk,
   input wire logic [13:0] ext_drive,
   input wire logic [13:0] ext_level,
   input wire logic [13:0] pullup_on,
   output logic [13:0] key_pin
);
   logic [13:0] float_pat = 14'h2A55;

   // an undriven pin without pull-up wanders every cycle
   always @(posedge pclk)
   begin
      float_pat <= ~float_pat;
   end

   always_comb
   begin
      for (int i = 0; i < 14; i++)
      begin
         key_pin[i] = ext_drive[i] ? ext_level[i] : (pullup_on[i] ? 1'b1 : float_pat[i]);
      end
   end
endmodule
`default_nettype wire

// File: verif/key_wakeup_detector_test.sv
// self-checking bench for the key wake-up detector
`timescale 1ns/1ps
`default_nettype none
module key_wakeup_detector_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [13:0] key_pin;
   logic [13:0] key_pullup_on;
   logic cg_key_detect;
   logic interrupt_controller_unit_key_request;
   logic [13:0] ext_drive = 14'h3FFF;
   logic [13:0] ext_level = 14'h3FFF;
   logic [31:0] lfsr = 32'hB7A4;
   logic [31:0] rdat;
   logic rerr;
   int k;
   int n_errors = 0;
   int n_checks = 0;

   always #10 pclk = ~pclk;

   key_wakeup_detector dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .key_pin(key_pin), .key_pullup_on(key_pullup_on),
      .cg_key_detect(cg_key_detect), .interrupt_controller_unit_key_request(interrupt_controller_unit_key_request));

   key_switch_model keys (.pclk(pclk), .ext_drive(ext_drive), .ext_level(ext_level),
      .pullup_on(key_pullup_on), .key_pin(key_pin));

   // ******************************
   // helpers
   // ******************************
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] cfg_word(input logic [1:0] c, input logic en);
      return {26'h0, c, 3'h0, en};
   endfunction

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkreq(input logic exp);
      chk({31'h0, interrupt_controller_unit_key_request}, {31'h0, exp});
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // entered just after a rising edge, leaves one idle cycle behind
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic setup(input int i, input logic [31:0] d);
      apb(1'b1, key_wakeup_pkg::SETUP_BASE_OFS + 8'(4 * i), d);
   endtask

   task automatic cfg_all(input logic [13:0] mask, input logic [1:0] c);
      for (int i = 0; i < 14; i++)
         setup(i, cfg_word(c, mask[i]));
   endtask

   task automatic pucfg(input logic [31:0] d);
      apb(1'b1, key_wakeup_pkg::PULLUP_CTRL_OFS, d);
   endtask

   task automatic clr();
      apb(1'b1, key_wakeup_pkg::CLEAR_OFS, 32'h0000000A);
   endtask

   initial
   begin
      wt(50000);
      n_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      finish_test();
   end

   // ******************************
   // main sequence
   // ******************************
   initial
   begin
      wt(12);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 14; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rdat, 32'h00000020);
      end
      for (int a = 8'h38; a <= 8'h44; a += 4)
      begin
         apb(1'b0, 8'(a), 32'h0);
         chk(rdat, 32'h0);
      end
      apb(1'b0, 8'h4C, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h01, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      for (int i = 0; i < 14; i++)
      begin
         lfsr = next_rand(lfsr);
         setup(i, lfsr);
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rdat, lfsr & 32'h00000031);
      end
      // every condition code on a random key, other keys floating
      for (int c = 0; c < 4; c++)
      begin
         lfsr = next_rand(lfsr);
         k = int'(lfsr % 14);
         ext_drive <= 14'h0001 << k;
         ext_level <= {14{~c[0]}};
         cfg_all(14'h0, c[1:0]);
         clr();
         setup(k, cfg_word(c[1:0], 1'b1));
         wt(6);
         chkreq(1'b0);
         ext_level[k] <= c[0];
         wt(6);
         chkreq(1'b1);
         ext_level[k] <= ~c[0];
         wt(6);
         chkreq(1'b1);
         clr();
         wt(2);
         chkreq(1'b0);
      end
      ext_drive <= 14'h3FFF;
      ext_level <= 14'h3FFF;
      cfg_all(14'h3FFF, key_wakeup_pkg::COND_FALL);
      clr();
      ext_level[2] <= 1'b0;
      wt(4);
      ext_level[9] <= 1'b0;
      wt(4);
      apb(1'b1, key_wakeup_pkg::CLEAR_OFS, 32'h00000005);
      chkreq(1'b1);
      apb(1'b0, key_wakeup_pkg::STATUS_OFS, 32'h0);
      chk(rdat, 32'h1);
      clr();
      wt(3);
      chkreq(1'b0);
      ext_level[5] <= 1'b0;
      wt(5);
      chkreq(1'b1);
      // keys end standby, detection level stays high
      apb(1'b1, key_wakeup_pkg::WAKE_SEL_OFS, 32'h1);
      wt(2);
      chk({31'h0, cg_key_detect}, 32'h1);
      apb(1'b0, key_wakeup_pkg::STATUS_OFS, 32'h0);
      chk(rdat, 32'h3);
      apb(1'b0, key_wakeup_pkg::LEVEL_OFS, 32'h0);
      chk(rdat, 32'h00003DDB);
      clr();
      wt(2);
      chk({30'h0, cg_key_detect, interrupt_controller_unit_key_request}, 32'h0);
      lfsr = next_rand(lfsr);
      pucfg(32'h1);
      cfg_all(lfsr[13:0], key_wakeup_pkg::COND_FALL);
      clr();
      wt(3);
      chk({18'h0, key_pullup_on}, {18'h0, lfsr[13:0]});
      pucfg(32'h0);
      wt(3);
      chk({18'h0, key_pullup_on}, 32'h0);
      // pulse and interval selects read back, pull-ups stay off
      lfsr = next_rand(lfsr);
      pucfg(lfsr & 32'h0000003C);
      apb(1'b0, key_wakeup_pkg::PULLUP_CTRL_OFS, 32'h0);
      chk(rdat, lfsr & 32'h0000003C);
      // dynamic: level code refused, then a falling edge is sampled
      pucfg(32'h3);
      cfg_all(14'h0, key_wakeup_pkg::COND_HIGH);
      clr();
      setup(0, cfg_word(key_wakeup_pkg::COND_HIGH, 1'b1));
      wt(1);
      chk({18'h0, key_pullup_on}, 32'h1);
      wt(8000);
      chkreq(1'b0);
      chk({18'h0, key_pullup_on}, 32'h0);
      ext_level[0] <= 1'b0;
      wt(5);
      setup(0, cfg_word(key_wakeup_pkg::COND_FALL, 1'b1));
      pucfg(32'h1);
      pucfg(32'h3);
      wt(2900);
      chkreq(1'b0);
      chk({18'h0, key_pullup_on}, 32'h1);
      wt(4800);
      chkreq(1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
